// file: pkg/rcm_pkg.sv
package rcm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_LOS_SETUP = 8'h00;
    localparam logic [7:0] OFS_LOS_MARGINS = 8'h04;
    localparam logic [7:0] OFS_LOS_NOMINAL = 8'h08;
    localparam logic [7:0] OFS_LOS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_ACT_STATE = 8'h10;
    localparam logic [7:0] OFS_ACT_EVENT = 8'h14;
    localparam logic [7:0] OFS_ACT_WINDOW = 8'h18;
    localparam logic [7:0] OFS_ACT_ACC = 8'h1C;
    localparam logic [7:0] OFS_ACT_REJ = 8'h20;
    localparam logic [7:0] OFS_ACT_NOMINAL = 8'h24;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h28;

    // Field positions and widths
    localparam int LOS_MASK_BIT = 0;
    localparam int LOS_DIV_LSB = 3;
    localparam int LOS_DIV_W = 5;
    localparam int LOS_GOOD_LSB = 8;
    localparam int LOS_FAIL_LSB = 12;
    localparam int TIMES_W = 4;
    localparam int LOS_ACC_LSB = 16;
    localparam int LOS_REJ_LSB = 0;
    localparam int LOS_W = 13;
    localparam int ACT_MASK_BIT = 20;
    localparam int ACT_DIV_LSB = 0;
    localparam int ACT_DIV_W = 19;
    localparam int ACT_W = 22;
    localparam int STS_LOS_BIT = 0;
    localparam int STS_INVALID_BIT = 1;
    localparam int SRST_UNIT0_BIT = 0;
    localparam int SRST_UNIT1_BIT = 1;

    // Compare and ratio widths shared by both monitors
    localparam int CW = 24;
    localparam int RW = 19;
    localparam int NUM_MON = 2;
    localparam int MON_LOS = 0;
    localparam int MON_ACT = 1;

    // Reset values
    localparam logic STS_RST = 1'b1;
    localparam logic EVT_RST = 1'b1;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    typedef struct packed {
        logic [CW-1:0] nom;
        logic [CW-1:0] acc;
        logic [CW-1:0] rej;
        logic [RW-1:0] ratio;
    } rcm_mon_cfg_t;

    typedef struct packed {
        logic win_end;
        logic accept;
        logic reject;
    } rcm_verdict_t;

    typedef enum logic [0:0] {
        RCM_BUS_IDLE,
        RCM_BUS_WRITE
    } rcm_bus_state_t;
endpackage

// file: rtl/rcm_ref_clock_monitor.sv
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - LOS window accepted when final count within nominal plus/minus accept margin.
// - LOS window rejected when final count outside nominal plus/minus reject margin.
// - LOS nominal count is expected clock periods per window, reference for margins.
// - LOS nominal count zero disables LOS monitor and forces LOS status high.
// - Activity status reads 0 qualified, 1 disqualified; resets to 1.
// - Activity event set and held while disqualified, sticky until software clears.
// - Writing one clears activity event; no effect while disqualification persists.
// - Activity event set on leaving reset; software clears after programming.
// - Activity failure mask removes activity status from the reference-invalid indication; zero uses status unmasked.
// - LOS window is one divided reference period; ratio 0 or 1 means none.
// - LOS status clears after good-times accepts, sets after fail-times rejects.
// - LOS failure mask removes LOS status from the reference-invalid indication.
module rcm_ref_clock_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ref_clk_in,
    output logic los_status,
    output logic act_status,
    output logic ref_invalid,
    output logic activity_unit1_soft_reset
);

    function automatic logic [rcm_pkg::CW-1:0] abs_diff(
        input logic [rcm_pkg::CW-1:0] a,
        input logic [rcm_pkg::CW-1:0] b
    );
        abs_diff = (a >= b) ? a - b : b - a;
    endfunction

    // Zero behaves as one for ratios and times alike
    function automatic logic [rcm_pkg::RW:0] at_least_one(input logic [rcm_pkg::RW-1:0] v);
        at_least_one = (v == '0) ? {{rcm_pkg::RW{1'b0}}, 1'b1} : {1'b0, v};
    endfunction

    // Configuration registers
    logic [31:0] los_setup_q, los_setup_d;
    logic [31:0] los_marg_q, los_marg_d;
    logic [31:0] los_nom_q, los_nom_d;
    logic [31:0] act_win_q, act_win_d;
    logic [31:0] act_acc_q, act_acc_d;
    logic [31:0] act_rej_q, act_rej_d;
    logic [31:0] act_nom_q, act_nom_d;
    logic [1:0] soft_rst_q, soft_rst_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    rcm_pkg::rcm_bus_state_t bus_q, bus_d;
    logic act_evt_clr;

    // Monitor state
    logic ref_s1_q, ref_s2_q, ref_prev_q;
    logic [rcm_pkg::RW-1:0] edge_cnt_q [rcm_pkg::NUM_MON];
    logic [rcm_pkg::RW-1:0] edge_cnt_d [rcm_pkg::NUM_MON];
    logic [rcm_pkg::CW-1:0] cyc_cnt_q [rcm_pkg::NUM_MON];
    logic [rcm_pkg::CW-1:0] cyc_cnt_d [rcm_pkg::NUM_MON];
    rcm_pkg::rcm_mon_cfg_t cfg [rcm_pkg::NUM_MON];
    rcm_pkg::rcm_verdict_t verdict [rcm_pkg::NUM_MON];
    logic ref_edge;
    logic act_srst;
    logic los_sts_q, los_sts_d;
    logic [rcm_pkg::TIMES_W-1:0] good_q, good_d, fail_q, fail_d;
    logic act_sts_q, act_sts_d;
    logic act_evt_q, act_evt_d;
    logic los_invalid, act_invalid;

    // ---------------- AHB-Lite slave ----------------
    logic addr_valid;
    assign addr_valid = hsel & hready & htrans[1] & (hsize == 3'h2);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        case (a)
            rcm_pkg::OFS_LOS_SETUP: read_mux = los_setup_q;
            rcm_pkg::OFS_LOS_MARGINS: read_mux = los_marg_q;
            rcm_pkg::OFS_LOS_NOMINAL: read_mux = los_nom_q;
            rcm_pkg::OFS_LOS_STATUS: read_mux = {30'h0000_0000, ref_invalid, los_sts_q};
            rcm_pkg::OFS_ACT_STATE: read_mux = {31'h0000_0000, act_sts_q};
            rcm_pkg::OFS_ACT_EVENT: read_mux = {31'h0000_0000, act_evt_q};
            rcm_pkg::OFS_ACT_WINDOW: read_mux = act_win_q;
            rcm_pkg::OFS_ACT_ACC: read_mux = act_acc_q;
            rcm_pkg::OFS_ACT_REJ: read_mux = act_rej_q;
            rcm_pkg::OFS_ACT_NOMINAL: read_mux = act_nom_q;
            rcm_pkg::OFS_SOFT_RESET: read_mux = {30'h0000_0000, soft_rst_q};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    // Masks keep reserved bits at zero
    localparam logic [31:0] LOS_SETUP_MASK = 32'h0000_FFF9;
    localparam logic [31:0] LOS_MARG_MASK = 32'h1FFF_1FFF;
    localparam logic [31:0] LOS_NOM_MASK = 32'h0000_1FFF;
    localparam logic [31:0] ACT_WIN_MASK = 32'h0017_FFFF;
    localparam logic [31:0] ACT_THR_MASK = 32'h003F_FFFF;

    always_comb begin
        los_setup_d = los_setup_q;
        los_marg_d = los_marg_q;
        los_nom_d = los_nom_q;
        act_win_d = act_win_q;
        act_acc_d = act_acc_q;
        act_rej_d = act_rej_q;
        act_nom_d = act_nom_q;
        soft_rst_d = soft_rst_q;
        rdata_d = rdata_q;
        wr_addr_d = wr_addr_q;
        bus_d = rcm_pkg::RCM_BUS_IDLE;
        act_evt_clr = 1'b0;
        case (bus_q)
            rcm_pkg::RCM_BUS_WRITE: begin
                case (wr_addr_q)
                    rcm_pkg::OFS_LOS_SETUP: los_setup_d = hwdata & LOS_SETUP_MASK;
                    rcm_pkg::OFS_LOS_MARGINS: los_marg_d = hwdata & LOS_MARG_MASK;
                    rcm_pkg::OFS_LOS_NOMINAL: los_nom_d = hwdata & LOS_NOM_MASK;
                    rcm_pkg::OFS_ACT_EVENT: act_evt_clr = hwdata[0];
                    rcm_pkg::OFS_ACT_WINDOW: act_win_d = hwdata & ACT_WIN_MASK;
                    rcm_pkg::OFS_ACT_ACC: act_acc_d = hwdata & ACT_THR_MASK;
                    rcm_pkg::OFS_ACT_REJ: act_rej_d = hwdata & ACT_THR_MASK;
                    rcm_pkg::OFS_ACT_NOMINAL: act_nom_d = hwdata & ACT_THR_MASK;
                    rcm_pkg::OFS_SOFT_RESET: soft_rst_d = hwdata[1:0];
                    default: ;
                endcase
            end
            rcm_pkg::RCM_BUS_IDLE: ;
            default: ;
        endcase
        if (addr_valid) begin
            if (hwrite) begin
                bus_d = rcm_pkg::RCM_BUS_WRITE;
                wr_addr_d = haddr[7:0];
            end else begin
                // Read data is captured in the address phase, so zero wait states
                rdata_d = read_mux(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            los_setup_q <= rcm_pkg::CFG_RST;
            los_marg_q <= rcm_pkg::CFG_RST;
            los_nom_q <= rcm_pkg::CFG_RST;
            act_win_q <= rcm_pkg::CFG_RST;
            act_acc_q <= rcm_pkg::CFG_RST;
            act_rej_q <= rcm_pkg::CFG_RST;
            act_nom_q <= rcm_pkg::CFG_RST;
            soft_rst_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            wr_addr_q <= 8'h00;
            bus_q <= rcm_pkg::RCM_BUS_IDLE;
        end else begin
            los_setup_q <= los_setup_d;
            los_marg_q <= los_marg_d;
            los_nom_q <= los_nom_d;
            act_win_q <= act_win_d;
            act_acc_q <= act_acc_d;
            act_rej_q <= act_rej_d;
            act_nom_q <= act_nom_d;
            soft_rst_q <= soft_rst_d;
            rdata_q <= rdata_d;
            wr_addr_q <= wr_addr_d;
            bus_q <= bus_d;
        end
    end

    // ---------------- Window measurement ----------------
    assign ref_edge = ref_s2_q & ~ref_prev_q;
    assign act_srst = soft_rst_q[rcm_pkg::SRST_UNIT0_BIT];
    assign activity_unit1_soft_reset = soft_rst_q[rcm_pkg::SRST_UNIT1_BIT];

    always_comb begin
        cfg[rcm_pkg::MON_LOS].nom = rcm_pkg::CW'(los_nom_q[rcm_pkg::LOS_W-1:0]);
        cfg[rcm_pkg::MON_LOS].acc =
            rcm_pkg::CW'(los_marg_q[rcm_pkg::LOS_ACC_LSB +: rcm_pkg::LOS_W]);
        cfg[rcm_pkg::MON_LOS].rej =
            rcm_pkg::CW'(los_marg_q[rcm_pkg::LOS_REJ_LSB +: rcm_pkg::LOS_W]);
        cfg[rcm_pkg::MON_LOS].ratio =
            rcm_pkg::RW'(los_setup_q[rcm_pkg::LOS_DIV_LSB +: rcm_pkg::LOS_DIV_W]);
        cfg[rcm_pkg::MON_ACT].nom = rcm_pkg::CW'(act_nom_q[rcm_pkg::ACT_W-1:0]);
        cfg[rcm_pkg::MON_ACT].acc = rcm_pkg::CW'(act_acc_q[rcm_pkg::ACT_W-1:0]);
        cfg[rcm_pkg::MON_ACT].rej = rcm_pkg::CW'(act_rej_q[rcm_pkg::ACT_W-1:0]);
        cfg[rcm_pkg::MON_ACT].ratio = act_win_q[rcm_pkg::ACT_DIV_LSB +: rcm_pkg::ACT_DIV_W];
    end

    always_comb begin
        for (int i = 0; i < rcm_pkg::NUM_MON; i++) begin
            verdict[i] = '0;
            edge_cnt_d[i] = edge_cnt_q[i];
            // Saturates so a dead-slow reference still lands outside the margins
            cyc_cnt_d[i] = (&cyc_cnt_q[i]) ? cyc_cnt_q[i] : cyc_cnt_q[i] + 1'b1;
            if (ref_edge) begin
                if ({1'b0, edge_cnt_q[i]} + 1'b1 >= at_least_one(cfg[i].ratio)) begin
                    verdict[i].win_end = 1'b1;
                    edge_cnt_d[i] = '0;
                    cyc_cnt_d[i] = '0;
                end else begin
                    edge_cnt_d[i] = edge_cnt_q[i] + 1'b1;
                end
            end
            verdict[i].accept = verdict[i].win_end &
                (abs_diff(cyc_cnt_q[i], cfg[i].nom) <= cfg[i].acc);
            verdict[i].reject = verdict[i].win_end &
                (abs_diff(cyc_cnt_q[i], cfg[i].nom) > cfg[i].rej);
        end
        if (act_srst) begin
            edge_cnt_d[rcm_pkg::MON_ACT] = '0;
            cyc_cnt_d[rcm_pkg::MON_ACT] = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_prev_q <= 1'b0;
            for (int i = 0; i < rcm_pkg::NUM_MON; i++) begin
                edge_cnt_q[i] <= '0;
                cyc_cnt_q[i] <= '0;
            end
        end else begin
            ref_s1_q <= ref_clk_in;
            ref_s2_q <= ref_s1_q;
            ref_prev_q <= ref_s2_q;
            for (int i = 0; i < rcm_pkg::NUM_MON; i++) begin
                edge_cnt_q[i] <= edge_cnt_d[i];
                cyc_cnt_q[i] <= cyc_cnt_d[i];
            end
        end
    end

    // ---------------- Qualification ----------------
    logic [rcm_pkg::TIMES_W:0] good_need, fail_need;
    assign good_need = (rcm_pkg::TIMES_W + 1)'(at_least_one(rcm_pkg::RW'(
        los_setup_q[rcm_pkg::LOS_GOOD_LSB +: rcm_pkg::TIMES_W])));
    assign fail_need = (rcm_pkg::TIMES_W + 1)'(at_least_one(rcm_pkg::RW'(
        los_setup_q[rcm_pkg::LOS_FAIL_LSB +: rcm_pkg::TIMES_W])));

    always_comb begin
        los_sts_d = los_sts_q;
        good_d = good_q;
        fail_d = fail_q;
        if (cfg[rcm_pkg::MON_LOS].nom == '0) begin
            los_sts_d = 1'b1;
            good_d = '0;
            fail_d = '0;
        end else if (verdict[rcm_pkg::MON_LOS].reject) begin
            good_d = '0;
            if (!los_sts_q) begin
                if ({1'b0, fail_q} + 1'b1 >= fail_need) begin
                    los_sts_d = 1'b1;
                    fail_d = '0;
                end else begin
                    fail_d = fail_q + 1'b1;
                end
            end
        end else if (verdict[rcm_pkg::MON_LOS].accept && los_sts_q) begin
            if ({1'b0, good_q} + 1'b1 >= good_need) begin
                los_sts_d = 1'b0;
                good_d = '0;
                fail_d = '0;
            end else begin
                good_d = good_q + 1'b1;
            end
        end
    end

    always_comb begin
        act_sts_d = act_sts_q;
        if (act_srst || cfg[rcm_pkg::MON_ACT].nom == '0) begin
            act_sts_d = 1'b1;
        end else if (verdict[rcm_pkg::MON_ACT].reject) begin
            act_sts_d = 1'b1;
        end else if (verdict[rcm_pkg::MON_ACT].accept) begin
            act_sts_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        act_evt_d = (act_evt_q & ~act_evt_clr) | act_sts_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            los_sts_q <= rcm_pkg::STS_RST;
            good_q <= '0;
            fail_q <= '0;
            act_sts_q <= rcm_pkg::STS_RST;
            act_evt_q <= rcm_pkg::EVT_RST;
        end else begin
            los_sts_q <= los_sts_d;
            good_q <= good_d;
            fail_q <= fail_d;
            act_sts_q <= act_sts_d;
            act_evt_q <= act_evt_d;
        end
    end

    assign los_invalid = los_sts_q & ~los_setup_q[rcm_pkg::LOS_MASK_BIT];
    assign act_invalid = act_sts_q & ~act_win_q[rcm_pkg::ACT_MASK_BIT];
    assign ref_invalid = los_invalid | act_invalid;
    assign los_status = los_sts_q;
    assign act_status = act_sts_q;

endmodule // rcm_ref_clock_monitor

// file: test/rcm_ref_clk_model.sv
`timescale 1ns/10ps
module rcm_ref_clk_model (
    input wire logic hclk,
    input wire logic [15:0] half_period,
    output logic ref_clk_in
);
    logic [15:0] cnt = 16'h0;
    initial ref_clk_in = 1'b0;
    // Falling-edge toggling keeps the input away from the monitor's sampling edge
    always @(negedge hclk) begin
        if (half_period == 16'h0) begin
            // A stopped reference stands low, it does not run free
            ref_clk_in <= 1'b0;
            cnt <= 16'h0;
        end else if (cnt + 16'h1 >= half_period) begin
            ref_clk_in <= ~ref_clk_in;
            cnt <= 16'h0;
        end else begin
            cnt <= cnt + 16'h1;
        end
    end
endmodule // rcm_ref_clk_model

// file: test/rcm_ref_clock_monitor_assertions.sv
`timescale 1ns/10ps
module rcm_ref_clock_monitor_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic ref_clk_in,
    input wire logic los_status,
    input wire logic act_status,
    input wire logic ref_invalid,
    input wire logic activity_unit1_soft_reset
);
    logic [3:0] since_rise_q;
    logic [3:0] since_rise_d;
    logic ref_q;
    logic wr_q;
    logic wr_d;
    always_comb begin
        wr_d = hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
        since_rise_d = since_rise_q + {3'h0, since_rise_q != 4'hF};
        if (ref_clk_in && !ref_q) begin
            since_rise_d = 4'h0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_rise_q <= 4'hF;
            ref_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            since_rise_q <= since_rise_d;
            ref_q <= ref_clk_in;
            wr_q <= wr_d;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_no_read;
        !(hsel && hready && htrans[1] && !hwrite && (hsize == 3'h2));
    endsequence
    // A verdict can only follow a reference edge by the sync and compare delay
    sequence s_after_edge;
        since_rise_q <= 4'h8;
    endsequence
    sequence s_after_write;
        $past(wr_q) || $past(wr_q, 2);
    endsequence
    a_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus answer is not zero-wait OKAY");
    a_rdata_stands: assert property (s_no_read |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_reset_status: assert property ($rose(hresetn) |->
        los_status && act_status && ref_invalid)
        else $error("statuses not set out of reset");
    a_invalid_cause: assert property (ref_invalid |-> los_status || act_status)
        else $error("reference invalid with both statuses clear");
    a_invalid_moves: assert property ($changed(ref_invalid) |->
        $changed(los_status) || $changed(act_status) || $past(wr_q))
        else $error("reference invalid moved without cause");
    a_act_fall_win: assert property ($fell(act_status) |-> s_after_edge)
        else $error("activity status cleared off a window boundary");
    a_act_rise_win: assert property ($rose(act_status) |-> s_after_edge or s_after_write)
        else $error("activity status set without window or write");
    a_los_fall_win: assert property ($fell(los_status) |-> s_after_edge)
        else $error("loss status cleared off a window boundary");
    a_los_rise_win: assert property ($rose(los_status) |-> s_after_edge or s_after_write)
        else $error("loss status set without window or write");
    a_soft1_write: assert property ($changed(activity_unit1_soft_reset) |-> $past(wr_q))
        else $error("soft reset output moved without a write");
endmodule // rcm_ref_clock_monitor_assertions

bind rcm_ref_clock_monitor rcm_ref_clock_monitor_assertions i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ref_clk_in(ref_clk_in), .los_status(los_status), .act_status(act_status),
    .ref_invalid(ref_invalid), .activity_unit1_soft_reset(activity_unit1_soft_reset)
);

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic ref_clk_in;
    logic los_status;
    logic act_status;
    logic ref_invalid;
    logic soft1;
    logic [15:0] half_period = 16'h0;
    int err_count = 0;
    int checks = 0;
    always #2.5 hclk = ~hclk;
    rcm_ref_clock_monitor i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_clk_in(ref_clk_in),
        .los_status(los_status), .act_status(act_status), .ref_invalid(ref_invalid),
        .activity_unit1_soft_reset(soft1));
    rcm_ref_clk_model i_ref (.hclk(hclk), .half_period(half_period), .ref_clk_in(ref_clk_in));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, ofs, wd, d);
    endtask
    task automatic rdc(input string name, input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, ofs, 32'h0, d);
        check(name, d, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // Soft reset wraps every activity reprogramming
    task automatic act_prog(input logic [31:0] window);
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h1);
        wr(rcm_pkg::OFS_ACT_WINDOW, window);
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h0);
    endtask
    logic [7:0] ofs_tab [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                 8'h20, 8'h24, 8'h28, 8'h2C};
    logic [31:0] rst_tab [12] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h1, 32'h1, 32'h0, 32'h0,
                                  32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] ones_tab [12] = '{32'hFFF9, 32'h1FFF1FFF, 32'h1FFF, 32'h3, 32'h1, 32'h1,
                                   32'h17FFFE, 32'h3FFFFF, 32'h3FFFFF, 32'h3FFFFF, 32'h3, 32'h0};
    task automatic test_reset_values();
        for (int i = 0; i < 12; i++) begin
            rdc("reset value", ofs_tab[i], rst_tab[i]);
        end
        check("status pins", {29'h0, los_status, act_status, ref_invalid}, 32'h7);
        $display("test_reset_values done");
    endtask
    task automatic test_reg_rw();
        // Event register skipped for writes: ones there would clear the sticky bit
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h1);
        for (int i = 0; i < 12; i++) begin
            if (i != 5) begin
                // The all-ones activity ratio is reserved, so its lowest bit stays clear
                wr(ofs_tab[i], (i == 6) ? 32'hFFFFFFFE : 32'hFFFFFFFF);
                rdc("field widths", ofs_tab[i], ones_tab[i]);
                wr(ofs_tab[i], (i == 10) ? 32'h1 : 32'h0);
            end
        end
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h0);
        $display("test_reg_rw done");
    endtask
    task automatic test_act();
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h1);
        wr(rcm_pkg::OFS_ACT_NOMINAL, 32'h14);
        wr(rcm_pkg::OFS_ACT_ACC, 32'h2);
        wr(rcm_pkg::OFS_ACT_REJ, 32'h4);
        act_prog(32'h0);
        half_period <= 16'hA;
        wait_cyc(200);
        check("act accept", {31'h0, act_status}, 32'h0);
        rdc("act state", rcm_pkg::OFS_ACT_STATE, 32'h0);
        rdc("act event sticky", rcm_pkg::OFS_ACT_EVENT, 32'h1);
        wr(rcm_pkg::OFS_ACT_EVENT, 32'h1);
        rdc("act event cleared", rcm_pkg::OFS_ACT_EVENT, 32'h0);
        act_prog(32'h2);
        half_period <= 16'h5;
        wait_cyc(200);
        check("act ratio two", {31'h0, act_status}, 32'h0);
        // Cleared while qualified, so only a real reject can set it again
        wr(rcm_pkg::OFS_ACT_EVENT, 32'h1);
        half_period <= 16'hA;
        wait_cyc(200);
        check("act reject", {31'h0, act_status}, 32'h1);
        rdc("act event set", rcm_pkg::OFS_ACT_EVENT, 32'h1);
        wr(rcm_pkg::OFS_ACT_EVENT, 32'h1);
        rdc("act event held", rcm_pkg::OFS_ACT_EVENT, 32'h1);
        $display("test_act done");
    endtask
    task automatic test_los();
        wr(rcm_pkg::OFS_LOS_MARGINS, 32'h00020004);
        wr(rcm_pkg::OFS_LOS_NOMINAL, 32'h14);
        wr(rcm_pkg::OFS_LOS_SETUP, 32'h1210);
        half_period <= 16'h5;
        wait_cyc(300);
        check("los divided accept", {30'h0, los_status, act_status}, 32'h0);
        check("ref valid", {31'h0, ref_invalid}, 32'h0);
        wr(rcm_pkg::OFS_LOS_SETUP, 32'h1211);
        wr(rcm_pkg::OFS_LOS_NOMINAL, 32'h0);
        wait_cyc(4);
        check("los disabled", {30'h0, los_status, ref_invalid}, 32'h2);
        wr(rcm_pkg::OFS_LOS_SETUP, 32'h1210);
        wait_cyc(2);
        check("los unmasked", {31'h0, ref_invalid}, 32'h1);
        wr(rcm_pkg::OFS_LOS_NOMINAL, 32'h14);
        wait_cyc(300);
        check("los requalified", {31'h0, los_status}, 32'h0);
        wr(rcm_pkg::OFS_LOS_SETUP, 32'h1209);
        wait_cyc(200);
        check("los reject", {31'h0, los_status}, 32'h1);
        act_prog(32'h00100004);
        wait_cyc(200);
        check("act masked", {30'h0, act_status, ref_invalid}, 32'h2);
        act_prog(32'h4);
        wait_cyc(2);
        check("act unmasked", {31'h0, ref_invalid}, 32'h1);
        rdc("los status reg", rcm_pkg::OFS_LOS_STATUS, 32'h3);
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h2);
        wait_cyc(1);
        check("unit1 soft reset", {31'h0, soft1}, 32'h1);
        wr(rcm_pkg::OFS_SOFT_RESET, 32'h0);
        $display("test_los done");
    endtask
    task automatic test_done();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_values();
        test_reg_rw();
        test_act();
        test_los();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        test_done();
    end
endmodule // testbench
